/* File: logic/asif_pkg.sv */
package asif_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ASIF_OPSTAT_ADDR = 8'h08; // operating_status
    localparam logic [7:0] ASIF_IRQFLG_ADDR = 8'h09; // interrupt_flags
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ASIF_NEWS_BIT = 3; // new_sample
    localparam int ASIF_EMPTY_BIT = 4; // fifo_is_empty
    localparam int ASIF_FULL_BIT = 5; // fifo_is_full
    localparam int ASIF_THR_BIT = 6; // fifo_at_threshold
    localparam int ASIF_PEND_BIT = 7; // irq_pending
    localparam int ASIF_WAKE_BIT = 2; // wake_irq
    localparam int ASIF_ACQ_BIT = 3; // acquire_irq
    localparam int ASIF_FEMP_BIT = 4; // fifo_empty_irq
    localparam int ASIF_FFUL_BIT = 5; // fifo_full_irq
    localparam int ASIF_FTHR_BIT = 6; // fifo_threshold_irq
    localparam int ASIF_SWK_BIT = 7; // watch_event_irq
    // ************************************************************
    // reset values, sizes, timing
    // ************************************************************
    localparam logic [7:0] ASIF_OPSTAT_RST = 8'h10; // empty flag set
    localparam logic [7:0] ASIF_IRQFLG_RST = 8'h00;
    localparam logic [7:0] ASIF_IRQ_MASK = 8'hFC; // bits 1:0 reserved
    localparam logic [5:0] ASIF_FIFO_DEPTH = 6'h20; // 32 slots
    localparam logic [1:0] ASIF_MODE_LAG = 2'h3; // heartbeat edges
    localparam logic [7:0] ASIF_BURST_MAX = 8'hFE; // 254 samples
    // ************************************************************
    // mode codes
    // ************************************************************
    typedef enum logic [2:0] {
        ASIF_SLEEP = 3'h0,
        ASIF_STANDBY = 3'h1,
        ASIF_WATCH = 3'h2,
        ASIF_CONT = 3'h5,
        ASIF_WSAMP = 3'h6,
        ASIF_BURST = 3'h7
    } asif_mode_type;
endpackage

/* File: logic/asif_evt_if.sv */
`timescale 1ns/10ps
`default_nettype none
// event strobes shared between mode sequencer and flag logic
interface asif_evt_if;
    logic [2:0] mode; // reported mode code
    logic wake_evt; // watch -> continuous auto move
    logic clocks_on; // clocks running
    logic sampling; // sample pipeline active
    logic detect_on; // activity detector armed
    logic fifo_on; // fifo operation allowed
    logic watch_fire; // detector hit in watch_and_sample
    logic rearm; // detector rearm request
    modport seq (output mode, wake_evt, clocks_on, sampling, detect_on,
                 fifo_on, watch_fire, input rearm);
    modport flg (input mode, wake_evt, clocks_on, sampling, detect_on,
                 fifo_on, watch_fire, output rearm);
endinterface
`default_nettype wire

/* File: logic/asif_mode_seq.sv */
`timescale 1ns/10ps
`default_nettype none
// mode sequencer: lagged mode report, auto moves, burst count
module asif_mode_seq (
    input wire logic clk_i,
    input wire logic rst_n_i, // synchronised reset
    input wire logic hb_i, // heartbeat clock, synchronised
    input wire logic mode_wr_i, // mode command strobe
    input wire logic [2:0] mode_cmd_i, // commanded mode
    input wire logic [7:0] burst_len_i, // 0 = continuous
    input wire logic sample_i, // new sample acquired
    input wire logic activity_i, // detector hit
    asif_evt_if.seq ev
);
    // ************************************************************
    // state
    // ************************************************************
    logic [2:0] mode_q; // reported mode
    logic [2:0] pend_q; // pending command
    logic pend_v_q; // command waiting
    logic [1:0] lag_q; // heartbeat edges seen
    logic hb_q; // heartbeat delayed
    logic [7:0] cnt_q; // burst samples taken
    logic stop_q; // detector stopped after event
    wire hb_edge = hb_i ^ hb_q; // any heartbeat transition
    wire in_watch = mode_q == asif_pkg::ASIF_WATCH;
    wire in_wsamp = mode_q == asif_pkg::ASIF_WSAMP;
    wire in_burst = mode_q == asif_pkg::ASIF_BURST;
    wire auto_wake = in_watch && activity_i && !pend_v_q;
    wire burst_done = in_burst && sample_i && burst_len_i != 8'h00
        && burst_len_i <= asif_pkg::ASIF_BURST_MAX
        && cnt_q + 8'h01 >= burst_len_i;
    wire apply = pend_v_q && hb_edge
        && lag_q == asif_pkg::ASIF_MODE_LAG - 2'h1;
    // reserved codes are dropped so the field never shows them
    wire cmd_take = mode_wr_i && mode_cmd_i != 3'h3
        && mode_cmd_i != 3'h4;
    // ************************************************************
    // mode update
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_q <= 3'h0;
            pend_q <= 3'h0;
            pend_v_q <= 1'b0;
            lag_q <= 2'h0;
            hb_q <= 1'b0;
        end
        else
        begin
            hb_q <= hb_i;
            if (cmd_take)
            begin
                // new command restarts the lag
                pend_q <= mode_cmd_i;
                pend_v_q <= 1'b1;
                lag_q <= 2'h0;
            end
            else if (apply)
            begin
                mode_q <= pend_q;
                pend_v_q <= 1'b0;
            end
            else if (pend_v_q && hb_edge)
                lag_q <= lag_q + 2'h1;
            else if (auto_wake)
                mode_q <= asif_pkg::ASIF_CONT;
            else if (burst_done)
                mode_q <= asif_pkg::ASIF_SLEEP;
        end
    end
    // ************************************************************
    // burst counter and detector lockout
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 8'h00;
            stop_q <= 1'b0;
        end
        else
        begin
            if (!in_burst)
                cnt_q <= 8'h00;
            else if (sample_i)
                cnt_q <= cnt_q + 8'h01;
            if (!in_wsamp)
                stop_q <= 1'b0;
            else if (ev.watch_fire)
                stop_q <= 1'b1;
            else if (ev.rearm)
                stop_q <= 1'b0;
        end
    end
    // ************************************************************
    // mode decode
    // ************************************************************
    assign ev.mode = mode_q;
    assign ev.wake_evt = auto_wake && !cmd_take;
    assign ev.clocks_on = mode_q != asif_pkg::ASIF_SLEEP;
    assign ev.sampling = mode_q == asif_pkg::ASIF_CONT || in_wsamp
        || in_burst || in_watch;
    assign ev.fifo_on = !in_watch && ev.sampling;
    assign ev.detect_on = in_wsamp && !stop_q;
    assign ev.watch_fire = ev.detect_on && activity_i;
endmodule
`default_nettype wire

/* File: logic/asif_status.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - mode field changes on the 3rd heartbeat edge after a command
// - mode codes in bits 2:0
// - standby: clocks running, no sampling
// - activity watch auto-moves to continuous
// - watch_and_sample runs detector, pipeline, fifo
// - burst takes 1-254 samples then sleeps
// - new_sample set on sample, clear-on-read
// - fifo_is_empty high when empty, reset 1
// - fifo_is_full high at 32 samples
// - fifo_at_threshold when count reaches threshold
// - irq_pending is OR of flags
// - flags set only when enabled
// - clear by read or write per interface
// - wake_irq on watch-to-continuous move
// - acquire_irq in continuous and burst only
// - fifo_empty_irq rearms after non-empty
// - fifo_full_irq rearms after not full
// - fifo_threshold_irq on reaching threshold
// - watch_event_irq event stops detector until rearm or exit
// - rearm option resets detector on clear
// - no rearm: detector stopped until exit
module asif_status (
    input wire logic clk_i,
    input wire logic rst_n_i, // async, active low
    input wire logic hb_i, // heartbeat clock pin
    input wire logic mode_wr_i, // mode command strobe
    input wire logic [2:0] mode_cmd_i, // commanded mode
    input wire logic [7:0] burst_len_i, // burst sample count
    input wire logic sample_i, // sample acquired
    input wire logic activity_i, // activity detector hit
    input wire logic [5:0] fifo_cnt_i, // samples in fifo 0..32
    input wire logic [4:0] fifo_thr_i, // threshold field
    input wire logic [7:0] irq_en_i, // interrupt enables
    input wire logic rearm_on_clear_i, // rearm option
    input wire logic wr_clr_sel_i, // i2c write-clear option
    input wire logic spi_sel_i, // spi interface in use
    input wire logic rd_i, // register read strobe
    input wire logic wr_i, // register write strobe
    input wire logic [7:0] addr_i, // register address
    output logic [7:0] rdata_o, // read data
    output logic [7:0] op_status_o, // operating_status
    output logic [7:0] irq_flags_o, // interrupt_flags
    output logic [2:0] mode_o, // current mode
    output logic clocks_on_o, // clocks running
    output logic sampling_o, // sample pipeline on
    output logic fifo_on_o, // fifo operation on
    output logic detect_on_o // activity detector armed
);
    // ************************************************************
    // reset and pin synchronisers
    // ************************************************************
    logic [1:0] rst_sync_q; // reset release chain
    logic rst_n; // synchronised reset
    logic hb_m_q; // heartbeat first stage
    logic hb_s_q; // heartbeat second stage
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hb_m_q <= 1'b0;
            hb_s_q <= 1'b0;
        end
        else
        begin
            hb_m_q <= hb_i;
            hb_s_q <= hb_m_q;
        end
    end
    // ************************************************************
    // mode sequencer
    // ************************************************************
    asif_evt_if ev ();
    asif_mode_seq u_seq (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .hb_i(hb_s_q),
        .mode_wr_i(mode_wr_i),
        .mode_cmd_i(mode_cmd_i),
        .burst_len_i(burst_len_i),
        .sample_i(sample_i),
        .activity_i(activity_i),
        .ev(ev.seq)
    );
    // ************************************************************
    // access decode
    // ************************************************************
    wire rd_op = rd_i && addr_i == asif_pkg::ASIF_OPSTAT_ADDR;
    wire rd_irq = rd_i && addr_i == asif_pkg::ASIF_IRQFLG_ADDR;
    wire wr_irq = wr_i && addr_i == asif_pkg::ASIF_IRQFLG_ADDR;
    wire clr_by_wr = spi_sel_i || wr_clr_sel_i;
    wire irq_clr = clr_by_wr ? wr_irq : rd_irq;
    // ************************************************************
    // fifo level conditions
    // ************************************************************
    wire lvl_empty = fifo_cnt_i == 6'h00;
    wire lvl_full = fifo_cnt_i >= asif_pkg::ASIF_FIFO_DEPTH;
    wire lvl_thr = fifo_cnt_i >= {1'b0, fifo_thr_i};
    wire in_cont = ev.mode == asif_pkg::ASIF_CONT;
    wire in_burst = ev.mode == asif_pkg::ASIF_BURST;
    // ************************************************************
    // flag state
    // ************************************************************
    logic new_q; // new_sample
    logic empty_q; // fifo_is_empty
    logic full_q; // fifo_is_full
    logic thr_q; // fifo_at_threshold
    logic empty_was_q; // previous empty level
    logic full_was_q; // previous full level
    logic thr_was_q; // previous threshold level
    logic [7:0] flg_q; // interrupt flags
    logic [7:0] flg_set; // flag set events this cycle
    logic [7:0] flg_d; // flag next value
    // ************************************************************
    // interrupt flag set terms, gated by enables
    // ************************************************************
    always_comb
    begin
        flg_set = 8'h00;
        flg_set[asif_pkg::ASIF_WAKE_BIT] = ev.wake_evt;
        flg_set[asif_pkg::ASIF_ACQ_BIT] = sample_i
            && (in_cont || in_burst);
        flg_set[asif_pkg::ASIF_FEMP_BIT] = lvl_empty
            && !empty_was_q;
        flg_set[asif_pkg::ASIF_FFUL_BIT] = lvl_full
            && !full_was_q;
        flg_set[asif_pkg::ASIF_FTHR_BIT] = lvl_thr
            && !thr_was_q;
        flg_set[asif_pkg::ASIF_SWK_BIT] = ev.watch_fire;
        flg_set = flg_set & irq_en_i & asif_pkg::ASIF_IRQ_MASK;
        // set wins over clear; one clear drops every flag
        flg_d = ((irq_clr ? 8'h00 : flg_q) | flg_set)
            & asif_pkg::ASIF_IRQ_MASK;
    end
    // detector rearm at the moment the watch flag is cleared
    assign ev.rearm = rearm_on_clear_i && irq_clr
        && flg_q[asif_pkg::ASIF_SWK_BIT];
    // ************************************************************
    // flag registers
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flg_q <= asif_pkg::ASIF_IRQFLG_RST;
            new_q <= 1'b0;
            empty_q <= 1'b1;
            full_q <= 1'b0;
            thr_q <= 1'b0;
            empty_was_q <= 1'b1;
            full_was_q <= 1'b0;
            thr_was_q <= 1'b0;
        end
        else
        begin
            flg_q <= flg_d;
            empty_q <= lvl_empty;
            full_q <= lvl_full;
            thr_q <= lvl_thr;
            empty_was_q <= lvl_empty;
            full_was_q <= lvl_full;
            thr_was_q <= lvl_thr;
            if (sample_i)
                new_q <= 1'b1;
            else if (rd_op)
                new_q <= 1'b0;
        end
    end
    // ************************************************************
    // register images
    // ************************************************************
    wire [7:0] op_img = {|flg_d, thr_q, full_q, empty_q, new_q,
        ev.mode};
    wire [7:0] op_next = {|flg_d, lvl_thr, lvl_full, lvl_empty,
        sample_i | (new_q & ~rd_op), ev.mode};
    wire [7:0] rd_sel = rd_op ? op_img
        : rd_irq ? flg_q : 8'h00;
    // ************************************************************
    // output registers
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_o <= 8'h00;
            op_status_o <= asif_pkg::ASIF_OPSTAT_RST;
            irq_flags_o <= asif_pkg::ASIF_IRQFLG_RST;
            mode_o <= 3'h0;
            clocks_on_o <= 1'b0;
            sampling_o <= 1'b0;
            fifo_on_o <= 1'b0;
            detect_on_o <= 1'b0;
        end
        else
        begin
            if (rd_i)
                rdata_o <= rd_sel;
            op_status_o <= op_next;
            irq_flags_o <= flg_d;
            mode_o <= ev.mode;
            clocks_on_o <= ev.clocks_on;
            sampling_o <= ev.sampling;
            fifo_on_o <= ev.fifo_on;
            detect_on_o <= ev.detect_on;
        end
    end
endmodule
`default_nettype wire

/* File: verif/asif_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// host model: register strobes toward the device
// ****
module asif_host (
    input wire logic clk_i,
    input wire logic spi_sel_i, // spi interface in use
    input wire logic wr_clr_sel_i, // write-clear chosen on i2c
    input wire logic [7:0] rdata_i, // read data from device
    output logic rd_o,
    output logic wr_o,
    output logic [7:0] addr_o
);
    // idle bus at time zero
    initial
    begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 8'h00;
    end
    // read: strobe held over one edge, data taken after it
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        rd_o = 1'b1;
        addr_o = a;
        @(posedge clk_i);
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a; // released bus shows no stale address
        d = rdata_i;
    endtask
    // write: strobe only, no data lines exist
    task automatic wr_reg(input logic [7:0] a);
        @(negedge clk_i);
        wr_o = 1'b1;
        addr_o = a;
        @(posedge clk_i);
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
    endtask
    // clear flags the way the chosen interface wants
    task automatic clr_flags(output logic [7:0] d);
        d = 8'h00;
        if (spi_sel_i || wr_clr_sel_i)
            wr_reg(asif_pkg::ASIF_IRQFLG_ADDR);
        else
            rd_reg(asif_pkg::ASIF_IRQFLG_ADDR, d);
    endtask
endmodule
`default_nettype wire

/* File: verif/asif_status_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// port checker for status and flag logic
// ****
module asif_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mode_wr_i,
    input wire logic sample_i,
    input wire logic activity_i,
    input wire logic [5:0] fifo_cnt_i,
    input wire logic [4:0] fifo_thr_i,
    input wire logic [7:0] irq_en_i,
    input wire logic wr_clr_sel_i,
    input wire logic spi_sel_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] op_status_o,
    input wire logic [7:0] irq_flags_o
);
    logic [2:0] up_q; // edges since reset release
    logic live; // design out of its delayed reset
    logic on09; // access aimed at interrupt_flags
    assign live = (up_q == 3'h4);
    assign on09 = (addr_i == asif_pkg::ASIF_IRQFLG_ADDR);
    // count up after release, then hold
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            up_q <= 3'h0;
        else if (!live)
            up_q <= up_q + 3'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i || !live);
    // no flag-setting event near the clear
    sequence calm;
        !sample_i && !activity_i && !$past(sample_i) && !$past(activity_i)
        && !$past(sample_i, 2) && !$past(activity_i, 2)
        && $stable(fifo_cnt_i) && ($past(fifo_cnt_i, 2) == fifo_cnt_i);
    endsequence
    chk_empty_lvl: assert property (
        op_status_o[4] == ($past(fifo_cnt_i) == 6'h00))
        else $error("empty level wrong");
    chk_full_lvl: assert property (
        op_status_o[5] == ($past(fifo_cnt_i) == asif_pkg::ASIF_FIFO_DEPTH))
        else $error("full level wrong");
    chk_thr_lvl: assert property (
        op_status_o[6] == ($past(fifo_cnt_i) >= {1'b0, $past(fifo_thr_i)}))
        else $error("threshold level wrong");
    chk_pend_or: assert property (
        op_status_o[7] == (|irq_flags_o))
        else $error("pending summary wrong");
    chk_resv_zero: assert property (
        irq_flags_o[1:0] == 2'h0)
        else $error("reserved flag bits set");
    chk_mode_code: assert property (
        !(op_status_o[2:0] inside {3'h3, 3'h4}))
        else $error("reserved mode code shown");
    chk_en_gate: assert property (
        (irq_flags_o & ~$past(irq_flags_o) & ~$past(irq_en_i)) == 8'h00)
        else $error("flag set while disabled");
    chk_rd_data: assert property (
        rd_i && on09 |=> rdata_o == $past(irq_flags_o))
        else $error("flag read data wrong");
    chk_rd_clear: assert property (
        rd_i && on09 && !spi_sel_i && !wr_clr_sel_i ##0 calm
        |=> irq_flags_o == 8'h00) else $error("read did not clear");
    chk_wr_clear: assert property (
        wr_i && on09 && (spi_sel_i || wr_clr_sel_i) ##0 calm
        |=> irq_flags_o == 8'h00) else $error("write did not clear");
    chk_rd_keeps: assert property (
        rd_i && on09 && (spi_sel_i || wr_clr_sel_i) |=>
        (irq_flags_o & $past(irq_flags_o)) == $past(irq_flags_o))
        else $error("read cleared in write-clear mode");
    chk_mode_lag: assert property (
        mode_wr_i |=> $stable(op_status_o[2:0]) [*2])
        else $error("mode field changed at once");
    chk_new_smp: assert property (
        sample_i |-> ##[1:2] op_status_o[3])
        else $error("new sample flag missing");
    cov_rd_clr: cover property (rd_i && on09 && (|irq_flags_o));
    cov_full: cover property (op_status_o[5]);
    cov_mode: cover property (mode_wr_i);
endmodule
bind asif_status asif_chk i_asif_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_wr_i(mode_wr_i),
    .sample_i(sample_i), .activity_i(activity_i), .fifo_cnt_i(fifo_cnt_i),
    .fifo_thr_i(fifo_thr_i), .irq_en_i(irq_en_i), .spi_sel_i(spi_sel_i),
    .wr_clr_sel_i(wr_clr_sel_i), .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i),
    .rdata_o(rdata_o), .op_status_o(op_status_o), .irq_flags_o(irq_flags_o)
);
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// status and flag testbench
// ****
module tb;
    logic clk_i = 1'b0;
    logic hb = 1'b0; // heartbeat pin
    logic rst_n_i, mode_wr, sample, activity, rearm, wr_clr, spi, rd, wr;
    logic [2:0] mode_cmd, mode;
    logic [7:0] burst_len, irq_en, addr, rdata, op_stat, irq_flg, dmy;
    logic [5:0] fifo_cnt;
    logic [4:0] fifo_thr;
    logic clk_on, smp, fifo_on, det_on;
    int miscompares = 0;
    int num_checks = 0;
    asif_status i_asif_status (.clk_i(clk_i), .rst_n_i(rst_n_i), .hb_i(hb),
        .mode_wr_i(mode_wr), .mode_cmd_i(mode_cmd), .burst_len_i(burst_len),
        .sample_i(sample), .activity_i(activity), .fifo_cnt_i(fifo_cnt),
        .fifo_thr_i(fifo_thr), .irq_en_i(irq_en), .rearm_on_clear_i(rearm),
        .wr_clr_sel_i(wr_clr), .spi_sel_i(spi), .rd_i(rd), .wr_i(wr),
        .addr_i(addr), .rdata_o(rdata), .op_status_o(op_stat),
        .irq_flags_o(irq_flg), .mode_o(mode), .clocks_on_o(clk_on),
        .sampling_o(smp), .fifo_on_o(fifo_on), .detect_on_o(det_on));
    asif_host i_asif_host (.clk_i(clk_i), .spi_sel_i(spi),
        .wr_clr_sel_i(wr_clr), .rdata_i(rdata), .rd_o(rd), .wr_o(wr),
        .addr_o(addr));
    // clock and free heartbeat
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    always
    begin
        repeat (4) @(negedge clk_i);
        hb <= ~hb;
    end
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_asif_host.rd_reg(a, d);
        chk(d, e);
    endtask
    // one-cycle activity or sample pulse
    task automatic pls(input logic act);
        @(negedge clk_i);
        activity = act;
        sample = ~act;
        @(negedge clk_i);
        activity = 1'b0;
        sample = 1'b0;
    endtask
    // bounded wait for a mode
    task automatic wt(input logic [2:0] m);
        int n;
        n = 0;
        while (mode !== m && n < 80)
        begin
            tick(1);
            n++;
        end
        tick(1);
        chk({5'h00, op_stat[2:0]}, {5'h00, m});
    endtask
    task automatic go(input logic [2:0] m);
        @(negedge clk_i);
        mode_wr = 1'b1;
        mode_cmd = m;
        @(negedge clk_i);
        mode_wr = 1'b0;
        wt(m);
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #(6000 * 100);
        miscompares++;
        complete_run();
    end
    // ****
    // main sequence
    // ****
    initial
    begin
        {rst_n_i, mode_wr, sample, activity, rearm, wr_clr, spi} = 7'h00;
        {mode_cmd, burst_len, fifo_cnt} = 17'h00000;
        fifo_thr = 5'h05;
        irq_en = 8'hFC;
        tick(12);
        rst_n_i = 1'b1;
        tick(4);
        chk(op_stat, 8'h10);
        chk(irq_flg, asif_pkg::ASIF_IRQFLG_RST);
        rdc(8'h08, 8'h10);
        rdc(8'h0A, 8'h00);
        fifo_cnt = 6'h20;
        tick(3);
        chk(op_stat, 8'hE0);
        chk(irq_flg, 8'h60);
        fifo_cnt = 6'h1F;
        tick(3);
        chk(op_stat, 8'hC0);
        fifo_cnt = 6'h00;
        tick(3);
        chk(irq_flg, 8'h70);
        rdc(8'h09, 8'h70);
        chk(op_stat, 8'h10);
        rdc(8'h09, 8'h00);
        irq_en = 8'h00;
        fifo_cnt = 6'h20;
        tick(3);
        chk(op_stat, 8'h60);
        fifo_cnt = 6'h00;
        tick(3);
        irq_en = 8'hFC;
        tick(3);
        chk(irq_flg, 8'h00);
        fifo_cnt = 6'h04;
        tick(3);
        chk(op_stat, 8'h00);
        fifo_cnt = 6'h05;
        tick(3);
        chk(irq_flg, 8'h40);
        fifo_cnt = 6'h00;
        tick(3);
        rdc(8'h09, 8'h50);
        wr_clr = 1'b1;
        fifo_cnt = 6'h20;
        tick(3);
        rdc(8'h09, 8'h60);
        chk(irq_flg, 8'h60);
        i_asif_host.clr_flags(dmy);
        chk(irq_flg, 8'h00);
        {wr_clr, spi} = 2'h1;
        fifo_cnt = 6'h00;
        tick(3);
        i_asif_host.clr_flags(dmy);
        chk(irq_flg, 8'h00);
        spi = 1'b0;
        go(asif_pkg::ASIF_STANDBY);
        chk({6'h00, clk_on, smp}, 8'h02);
        pls(1'b0);
        chk(irq_flg, 8'h00);
        rdc(8'h08, 8'h19);
        chk(op_stat, 8'h11);
        go(asif_pkg::ASIF_CONT);
        pls(1'b0);
        tick(1);
        rdc(8'h09, 8'h08);
        go(asif_pkg::ASIF_WATCH);
        chk({6'h00, smp, fifo_on}, 8'h02);
        pls(1'b1);
        wt(asif_pkg::ASIF_CONT);
        rdc(8'h09, 8'h04);
        go(asif_pkg::ASIF_WSAMP);
        chk({5'h00, smp, fifo_on, det_on}, 8'h07);
        pls(1'b1);
        tick(2);
        rdc(8'h09, 8'h80);
        pls(1'b1);
        tick(2);
        chk(irq_flg, 8'h00);
        go(asif_pkg::ASIF_CONT);
        go(asif_pkg::ASIF_WSAMP);
        rearm = 1'b1;
        pls(1'b1);
        tick(2);
        rdc(8'h09, 8'h80);
        pls(1'b1);
        tick(2);
        rdc(8'h09, 8'h80);
        burst_len = 8'h02;
        go(asif_pkg::ASIF_BURST);
        pls(1'b0);
        chk({5'h00, mode}, 8'h07);
        pls(1'b0);
        wt(asif_pkg::ASIF_SLEEP);
        rdc(8'h09, 8'h08);
        // reserved command code must leave sleep in place
        @(negedge clk_i);
        {mode_wr, mode_cmd} = 4'hB;
        tick(1);
        mode_wr = 1'b0;
        tick(20);
        chk({5'h00, op_stat[2:0]}, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
